/* src/cc_channel.v */
/*
 * One capture/compare channel of a 16-bit timer with a classic Wishbone
 * register slave, sticky event status with mask, and the shared vector.
 * Assumes the counter, its mode and period value, and the period match
 * come from the timer core on the same clock; all inputs are synchronous
 * to CLK; other channels' pending lines arrive on PEND_IN.
 */
`timescale 1ns/1ns
`include "cc_channel_defines.vh"

module cc_channel #(
    parameter CHAN_NUM = 1
) (
    // Clock, reset, enable
    input wire CLK,
    input wire RST_B,
    input wire CE,
    // Wishbone slave
    input wire CYC_I,
    input wire STB_I,
    input wire WE_I,
    input wire [7:0] ADR_I,
    input wire [3:0] SEL_I,
    input wire [31:0] DAT_I,
    output reg [31:0] DAT_O,
    output wire ACK_O,
    // Timer core
    input wire [15:0] COUNT_VALUE,
    input wire [1:0] COUNT_MODE,
    input wire [15:0] PERIOD_VALUE,
    input wire PERIOD_MATCH,
    // Channel pins
    input wire CH_IN_A,
    input wire CH_IN_B,
    output wire CH_OUT,
    // Interrupts and vector sharing
    input wire [6:0] PEND_IN,
    output reg [6:0] VEC_CLR,
    output wire CH_IRQ,
    output wire IRQ
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg [1:0] edge_sel_q;
    reg [1:0] src_sel_q;
    reg sync_en_q;
    reg [1:0] load_ev_q;
    reg func_q;
    reg [2:0] wave_q;
    reg ie_q;
    reg pin_level_q;
    reg ovr_q;
    reg flag_q;
    reg [15:0] value_q;
    reg [15:0] latch_q;
    reg out_q;
    reg in_sync_q;
    reg in_prev_q;
    reg match_prev_q;
    reg [`ST_WIDTH-1:0] status_q;
    reg [`ST_WIDTH-1:0] mask_q;
    reg ack_q;

    // ------------------------------------------------------------------
    // Input selection and edge detection
    // ------------------------------------------------------------------
    reg sel_in;
    // Routed input
    always @* begin
        case (src_sel_q)
            `SRC_A: sel_in = CH_IN_A;
            `SRC_B: sel_in = CH_IN_B;
            `SRC_GND: sel_in = 1'b0;
            `SRC_VCC: sel_in = 1'b1;
            default: sel_in = 1'b0;
        endcase
    end

    // Sync mode looks one clock later, so edges line up with the timer
    wire cap_src = sync_en_q ? in_sync_q : sel_in;
    wire rise = cap_src & ~in_prev_q;
    wire fall = ~cap_src & in_prev_q;
    reg cap_edge;
    always @* begin
        case (edge_sel_q)
            `EDGE_RISE: cap_edge = rise;
            `EDGE_FALL: cap_edge = fall;
            `EDGE_BOTH: cap_edge = rise | fall;
            default: cap_edge = 1'b0;
        endcase
    end
    wire cap_ev = func_q & cap_edge;
    wire ovr_ev = cap_ev & flag_q;

    // ------------------------------------------------------------------
    // Compare and shadow latch loading
    // ------------------------------------------------------------------
    wire match = (COUNT_VALUE == latch_q);
    // Only the arrival at the value counts, a stopped counter fires once
    wire match_ev = ~func_q & match & ~match_prev_q;
    wire at_zero = (COUNT_VALUE == 16'h0000);
    reg load_ev;
    always @* begin
        case (load_ev_q)
            `LOAD_ZERO: load_ev = at_zero;
            `LOAD_PERIOD: load_ev = at_zero |
                ((COUNT_MODE == `MODE_UPDOWN) & (COUNT_VALUE == PERIOD_VALUE));
            `LOAD_SELF: load_ev = match;
            default: load_ev = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Wishbone decode
    // ------------------------------------------------------------------
    wire req = CYC_I & STB_I & ~ack_q;
    wire acc = CE & req;
    wire wr = acc & WE_I;
    wire rd = acc & ~WE_I;
    wire hit_ctl = (ADR_I == `OFS_CONTROL);
    wire hit_val = (ADR_I == `OFS_VALUE);
    wire hit_vec = (ADR_I == `OFS_VECTOR);
    wire hit_st = (ADR_I == `OFS_STATUS);
    wire hit_msk = (ADR_I == `OFS_MASK);
    wire wr_lo = SEL_I[0];
    wire wr_hi = SEL_I[1];
    wire wr_ctl = wr & hit_ctl;
    wire wr_val = wr & hit_val;
    assign ACK_O = ack_q;

    // Byte-lane merge for the value register
    wire [15:0] val_wdata = {wr_hi ? DAT_I[15:8] : value_q[15:8],
                             wr_lo ? DAT_I[7:0] : value_q[7:0]};

    // ------------------------------------------------------------------
    // Vector priority
    // ------------------------------------------------------------------
    wire own_pend = flag_q & ie_q;
    reg [6:0] pend;
    reg [15:0] vec;
    reg [6:0] win;
    integer i;
    // Channel one highest, overflow lowest
    always @* begin
        pend = PEND_IN;
        pend[CHAN_NUM-1] = own_pend;
        vec = `VEC_NONE;
        win = 7'h00;
        for (i = 6; i >= 0; i = i - 1) begin
            if (pend[i]) begin
                vec = {11'h000, i[3:0] + 4'h1, 1'b0};
                win = 7'h01 << i;
            end
        end
    end
    wire vec_rd = rd & hit_vec;
    wire own_clr = vec_rd & win[CHAN_NUM-1];

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire [15:0] ctl_rd = {edge_sel_q, src_sel_q, sync_en_q, load_ev_q, func_q,
                          wave_q, ie_q, sel_in, pin_level_q, ovr_q, flag_q};
    reg [15:0] rdata;
    always @* begin
        rdata = 16'h0000;
        if (hit_ctl) rdata = ctl_rd;
        if (hit_val) rdata = value_q;
        if (hit_vec) rdata = vec;
        if (hit_st) rdata = {13'h0000, status_q};
        if (hit_msk) rdata = {13'h0000, mask_q};
    end

    // ------------------------------------------------------------------
    // Bus response: one wait state, unmapped reads return zero
    // ------------------------------------------------------------------
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ack_q <= 1'b0;
            DAT_O <= 32'h00000000;
            VEC_CLR <= 7'h00;
        end else if (CE) begin
            ack_q <= req;
            VEC_CLR <= 7'h00;
            if (rd) begin
                DAT_O <= {16'h0000, rdata};
            end
            if (vec_rd) begin
                // Foreign sources are cleared by their owners
                VEC_CLR <= win & ~(7'h01 << (CHAN_NUM - 1));
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            {edge_sel_q, src_sel_q, sync_en_q, load_ev_q, func_q} <= 8'h00;
            {wave_q, ie_q, pin_level_q} <= 5'h00;
        end else if (CE & wr_ctl) begin
            if (wr_hi) begin
                edge_sel_q <= DAT_I[`F_EDGE_HI:`F_EDGE_LO];
                src_sel_q <= DAT_I[`F_SRC_HI:`F_SRC_LO];
                sync_en_q <= DAT_I[`F_SYNC];
                load_ev_q <= DAT_I[`F_LOAD_HI:`F_LOAD_LO];
                func_q <= DAT_I[`F_FUNC];
            end
            if (wr_lo) begin
                wave_q <= DAT_I[`F_WAVE_HI:`F_WAVE_LO];
                ie_q <= DAT_I[`F_IE];
                pin_level_q <= DAT_I[`F_PIN];
            end
        end
    end

    // ------------------------------------------------------------------
    // Flags: hardware set wins over any software or vector clear
    // ------------------------------------------------------------------
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ovr_q <= 1'b0;
            flag_q <= 1'b0;
        end else if (CE) begin
            if (ovr_ev) begin
                ovr_q <= 1'b1;
            end else if (wr_ctl & wr_lo) begin
                ovr_q <= DAT_I[`F_OVR];
            end
            if (cap_ev | match_ev) begin
                flag_q <= 1'b1;
            end else if (wr_ctl & wr_lo) begin
                flag_q <= DAT_I[`F_FLAG];
            end else if (own_clr) begin
                flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Value register and shadow latch
    // ------------------------------------------------------------------
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            value_q <= `RST_VALUE;
            latch_q <= `RST_VALUE;
        end else if (CE) begin
            // A capture beats a software write in the same cycle
            if (cap_ev) begin
                value_q <= COUNT_VALUE;
            end else if (wr_val) begin
                value_q <= val_wdata;
            end
            if (wr_val & (load_ev_q == `LOAD_WRITE)) begin
                latch_q <= val_wdata;
            end else if (load_ev) begin
                latch_q <= value_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Edge history
    // ------------------------------------------------------------------
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            in_sync_q <= 1'b0;
            in_prev_q <= 1'b0;
            // Counter and latch both sit at zero out of reset: no false match
            match_prev_q <= 1'b1;
        end else if (CE) begin
            in_sync_q <= sel_in;
            in_prev_q <= cap_src;
            match_prev_q <= match;
        end
    end

    // ------------------------------------------------------------------
    // Output waveform unit
    // ------------------------------------------------------------------
    // On channel one the two events coincide, so mixed modes degrade
    reg out_d;
    always @* begin
        out_d = out_q;
        case (wave_q)
            3'h0: out_d = pin_level_q;
            3'h1: if (match_ev) out_d = 1'b1;
            3'h2: begin
                if (match_ev) out_d = ~out_q;
                if (PERIOD_MATCH) out_d = 1'b0;
            end
            3'h3: begin
                if (match_ev) out_d = 1'b1;
                if (PERIOD_MATCH) out_d = 1'b0;
            end
            3'h4: if (match_ev) out_d = ~out_q;
            3'h5: if (match_ev) out_d = 1'b0;
            3'h6: begin
                if (match_ev) out_d = ~out_q;
                if (PERIOD_MATCH) out_d = 1'b1;
            end
            3'h7: begin
                if (match_ev) out_d = 1'b0;
                if (PERIOD_MATCH) out_d = 1'b1;
            end
            default: out_d = out_q;
        endcase
    end

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            out_q <= 1'b0;
        end else if (CE) begin
            out_q <= out_d;
        end
    end
    assign CH_OUT = out_q;

    // ------------------------------------------------------------------
    // Sticky status, mask and interrupt lines
    // ------------------------------------------------------------------
    wire [`ST_WIDTH-1:0] st_set = {ovr_ev, match_ev, cap_ev};
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            status_q <= {`ST_WIDTH{1'b0}};
            mask_q <= {`ST_WIDTH{1'b0}};
        end else if (CE) begin
            if (rd & hit_st) begin
                status_q <= st_set;
            end else begin
                status_q <= status_q | st_set;
            end
            if (wr & hit_msk & wr_lo) begin
                mask_q <= DAT_I[`ST_WIDTH-1:0];
            end
        end
    end
    assign IRQ = |(status_q & mask_q);
    assign CH_IRQ = own_pend;

endmodule

/* src/cc_channel_defines.vh */
/*
 * Constants of the capture/compare channel: register offsets, field
 * positions, reset values and code points.
 * Assumes it is included by bare name from the channel design file.
 */
`ifndef CC_CHANNEL_DEFINES_VH
`define CC_CHANNEL_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_VALUE 8'h04
`define OFS_VECTOR 8'h08
`define OFS_STATUS 8'h0C
`define OFS_MASK 8'h10

// ----------------------------------------------------------------------
// Channel control field positions
// ----------------------------------------------------------------------
`define F_EDGE_HI 15
`define F_EDGE_LO 14
`define F_SRC_HI 13
`define F_SRC_LO 12
`define F_SYNC 11
`define F_LOAD_HI 10
`define F_LOAD_LO 9
`define F_FUNC 8
`define F_WAVE_HI 7
`define F_WAVE_LO 5
`define F_IE 4
`define F_LEVEL_IN 3
`define F_PIN 2
`define F_OVR 1
`define F_FLAG 0

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define RST_CONTROL 16'h0000
`define RST_VALUE 16'h0000
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define SRC_A 2'h0
`define SRC_B 2'h1
`define SRC_GND 2'h2
`define SRC_VCC 2'h3
`define LOAD_WRITE 2'h0
`define LOAD_ZERO 2'h1
`define LOAD_PERIOD 2'h2
`define LOAD_SELF 2'h3
`define MODE_UPDOWN 2'h3
`define VEC_NONE 16'h0000
`define VEC_OVERFLOW 16'h000E
// Status bits: capture, compare match, overrun
`define ST_CAPTURE 0
`define ST_COMPARE 1
`define ST_OVERRUN 2
`define ST_WIDTH 3

`endif

/* dv/cc_channel_sva.sv */
/*
 * Checker of the channel's bus, output and vector-sharing ports.
 * Assumes one clock domain and is bound to every cc_channel instance.
 */
`timescale 1ns/1ns
module cc_channel_sva #(
    parameter CHAN_NUM = 1
) (
    // Watched ports
    input wire CLK, RST_B, CE, CYC_I, STB_I, WE_I,
    input wire [7:0] ADR_I,
    input wire [31:0] DAT_O,
    input wire ACK_O, CH_OUT,
    input wire [6:0] PEND_IN, VEC_CLR
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);

    chk_ack_pulse: assert property (ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");
    chk_ack_latency: assert property (CYC_I && STB_I && !ACK_O && CE |=> ACK_O)
        else $error("ack missing one cycle after request");
    chk_dat_upper: assert property (ACK_O |-> DAT_O[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    chk_dat_hold: assert property ($changed(DAT_O) |-> ACK_O)
        else $error("read data moved without ack");
    // Vector read: even code, never above the overflow code
    chk_vec_even: assert property (
        ACK_O && $past(ADR_I) == 8'h08 && !$past(WE_I) |-> !DAT_O[0] && DAT_O <= 32'hE)
        else $error("vector code malformed");
    chk_vec_prio: assert property (
        ACK_O && $past(ADR_I) == 8'h08 && !$past(WE_I) && $past(PEND_IN[0]) && CHAN_NUM != 1
        |-> DAT_O == 32'h2)
        else $error("channel one not reported first");
    chk_clr_onehot: assert property ($onehot0(VEC_CLR) && !VEC_CLR[CHAN_NUM-1])
        else $error("vector clear not one foreign source");
    chk_clr_cause: assert property (VEC_CLR != 7'h00 |-> ACK_O || $past(ACK_O))
        else $error("vector clear without a read");
    // A frozen clock enable must hold the registered pin
    chk_ce_freeze: assert property (!CE |=> $stable(CH_OUT))
        else $error("output moved while enable low");
endmodule
bind cc_channel cc_channel_sva #(.CHAN_NUM(CHAN_NUM)) u_sva (
    .CLK(CLK), .RST_B(RST_B), .CE(CE), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .CH_OUT(CH_OUT),
    .PEND_IN(PEND_IN), .VEC_CLR(VEC_CLR)
);

/* dv/cc_far_side.sv */
/*
 * Model of the channel's far side: two capture inputs and the output pin.
 * Assumes the bench calls drive just after a rising edge of the timer clock.
 */
`timescale 1ns/1ns
module cc_far_side (
    // Timer clock
    input wire clk,
    // Capture inputs and output pin
    output logic in_a,
    output logic in_b,
    input wire ch_out
);
    // Start low so no edge shows right after reset
    initial begin
        in_a = 1'b0;
        in_b = 1'b0;
    end
    // Change levels after an edge; inputs are synchronous to the clock
    task drive(input logic a, input logic b);
        in_a <= a;
        in_b <= b;
        @(posedge clk);
    endtask
endmodule

/* dv/tb.sv */
/*
 * Self-checking bench of one capture/compare channel (channel two).
 * Assumes the far-side model and the bound checker are compiled first.
 */
`timescale 1ns/1ns
`include "cc_channel_defines.vh"
module tb;
    logic CLK, RST_B, CE, CYC_I, STB_I, WE_I, PERIOD_MATCH, saw_clr;
    logic [7:0] ADR_I;
    logic [31:0] DAT_I, q;
    logic [15:0] COUNT_VALUE;
    logic [1:0] COUNT_MODE;
    logic [3:0] SEL_I;
    logic [6:0] PEND_IN;
    wire [31:0] DAT_O;
    wire [6:0] VEC_CLR;
    wire ACK_O, CH_OUT, CH_IRQ, IRQ, CH_IN_A, CH_IN_B;
    int n_fail, checked, cycles;

    cc_channel #(.CHAN_NUM(2)) i_cc_channel (.CLK(CLK), .RST_B(RST_B), .CE(CE),
        .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
        .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .COUNT_VALUE(COUNT_VALUE),
        .COUNT_MODE(COUNT_MODE), .PERIOD_VALUE(16'h00FF), .PERIOD_MATCH(PERIOD_MATCH),
        .CH_IN_A(CH_IN_A), .CH_IN_B(CH_IN_B), .CH_OUT(CH_OUT), .PEND_IN(PEND_IN),
        .VEC_CLR(VEC_CLR), .CH_IRQ(CH_IRQ), .IRQ(IRQ));
    cc_far_side far (.clk(CLK), .in_a(CH_IN_A), .in_b(CH_IN_B), .ch_out(CH_OUT));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    // Hang guard and vector-clear watcher
    always @(posedge CLK) begin
        cycles++;
        if (VEC_CLR[0] === 1'b1) saw_clr <= 1'b1;
        if (cycles == 5000) begin
            n_fail++;
            give_verdict;
        end
    end
    task give_verdict;
        $display("fails %0d checks %0d", n_fail, checked);
        if (n_fail == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tk(input int n);
        repeat (n) @(posedge CLK);
    endtask
    // Classic cycle: hold everything until ack is sampled, then idle one cycle
    // Waits for ack however long it takes; only the hang guard ends a wait
    task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= w;
        ADR_I <= a;
        SEL_I <= 4'h3;
        DAT_I <= {16'h0000, d};
        do begin
            @(posedge CLK);
        end while (ACK_O !== 1'b1);
        q = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        @(posedge CLK);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        wb(1'b0, a, 16'h0000);
        chk(q & m, e);
    endtask
    function logic [15:0] ctl(logic [1:0] e, s, logic y, logic [1:0] l, logic f,
        logic [2:0] w, logic ie, p);
        return {e, s, y, l, f, w, ie, 1'b0, p, 2'b00};
    endfunction
    task cnt(input logic [15:0] v);
        COUNT_VALUE <= v;
        tk(3);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regs;
        rd(`OFS_CONTROL, 32'h0, 32'hFFF7);
        rd(`OFS_VALUE, 32'h0);
        rd(`OFS_VECTOR, 32'h0);
        wb(1'b1, 8'h20, 16'hFFFF);
        rd(8'h20, 32'h0);
        wb(1'b1, `OFS_VALUE, 16'hA5C3);
        rd(`OFS_VALUE, 32'hA5C3);
    endtask
    task t_levels;
        int s;
        far.drive(1'b1, 1'b0);
        for (s = 0; s < 4; s++) begin
            wb(1'b1, `OFS_CONTROL, ctl(0, s[1:0], 0, 0, 0, 0, 0, 0));
            rd(`OFS_CONTROL, {28'h0, (s == 0 || s == 3), 3'h0}, 32'h8);
        end
        far.drive(1'b0, 1'b0);
    endtask
    task t_capture;
        int e, y;
        logic [15:0] v;
        for (e = 1; e < 4; e++) for (y = 0; y < 2; y++) begin
            // Counter away from zero first, so the cleared latch makes no match
            COUNT_VALUE <= 16'h1100 + e[15:0];
            wb(1'b1, `OFS_VALUE, 16'h0000);
            v = 16'h0000;
            wb(1'b1, `OFS_CONTROL, ctl(e[1:0], 0, y[0], 0, 1, 0, 0, 0));
            far.drive(1'b1, 1'b0);
            tk(4);
            if (e[0]) v = 16'h1100 + e[15:0];
            rd(`OFS_VALUE, {16'h0, v});
            COUNT_VALUE <= 16'h2200 + e[15:0];
            far.drive(1'b0, 1'b0);
            tk(4);
            if (e[1]) v = 16'h2200 + e[15:0];
            rd(`OFS_VALUE, {16'h0, v});
            rd(`OFS_CONTROL, {30'h0, e == 3, 1'b1}, 32'h3);
            wb(1'b1, `OFS_CONTROL, 16'h0000);
            rd(`OFS_CONTROL, 32'h0, 32'h3);
        end
    endtask
    task t_irq;
        rd(`OFS_STATUS, 32'h5);
        rd(`OFS_STATUS, 32'h0);
        wb(1'b1, `OFS_MASK, 16'h0001);
        wb(1'b1, `OFS_CONTROL, ctl(1, 0, 0, 0, 1, 0, 0, 0));
        far.drive(1'b1, 1'b0);
        tk(3);
        chk(CH_IRQ, 32'h0);
        chk(IRQ, 32'h1);
        wb(1'b1, `OFS_CONTROL, ctl(1, 0, 0, 0, 1, 0, 1, 0) | 16'h0001);
        chk(CH_IRQ, 32'h1);
        rd(`OFS_STATUS, 32'h1);
        chk(IRQ, 32'h0);
        wb(1'b1, `OFS_MASK, 16'h0000);
        far.drive(1'b0, 1'b0);
        far.drive(1'b1, 1'b0);
        tk(3);
        chk(IRQ, 32'h0);
        rd(`OFS_STATUS, 32'h5);
        wb(1'b1, `OFS_CONTROL, 16'h0000);
        chk(CH_IRQ, 32'h0);
        far.drive(1'b0, 1'b0);
    endtask
    task t_vector;
        PEND_IN <= 7'h41;
        tk(1);
        rd(`OFS_VECTOR, 32'h2);
        chk(saw_clr, 32'h1);
        PEND_IN <= 7'h40;
        wb(1'b1, `OFS_CONTROL, 16'h0011);
        rd(`OFS_VECTOR, 32'h4);
        rd(`OFS_VECTOR, 32'hE);
        rd(`OFS_CONTROL, 32'h0, 32'h1);
        PEND_IN <= 7'h00;
        tk(1);
        rd(`OFS_VECTOR, 32'h0);
    endtask
    task t_wave;
        logic s;
        int m;
        CE <= 1'b0;
        tk(2);
        CE <= 1'b1;
        wb(1'b1, `OFS_VALUE, 16'h0050);
        wb(1'b1, `OFS_CONTROL, ctl(0, 0, 0, 0, 0, 0, 0, 1));
        tk(2);
        chk(CH_OUT, 32'h1);
        wb(1'b1, `OFS_CONTROL, 16'h0000);
        tk(2);
        chk(CH_OUT, 32'h0);
        s = 1'b0;
        // Channel two, so the dual-event modes are meaningful here
        for (m = 1; m < 8; m++) begin
            wb(1'b1, `OFS_CONTROL, ctl(0, 0, 0, 0, 0, m[2:0], 0, 0));
            cnt(16'h004F);
            cnt(16'h0050);
            s = (m == 1 || m == 3) ? 1'b1 : (m == 5 || m == 7) ? 1'b0 : !s;
            chk(CH_OUT, {31'h0, s});
            PERIOD_MATCH <= 1'b1;
            tk(1);
            PERIOD_MATCH <= 1'b0;
            tk(2);
            if (m == 2 || m == 3) s = 1'b0;
            else if (m >= 6) s = 1'b1;
            chk(CH_OUT, {31'h0, s});
        end
        rd(`OFS_STATUS, 32'h2);
        wb(1'b1, `OFS_CONTROL, ctl(0, 0, 0, 1, 0, 0, 0, 0));
        wb(1'b1, `OFS_VALUE, 16'h0060);
        cnt(16'h005F);
        cnt(16'h0060);
        rd(`OFS_STATUS, 32'h0);
        cnt(16'h0000);
        cnt(16'h005F);
        cnt(16'h0060);
        rd(`OFS_STATUS, 32'h2);
    endtask
    // Shadow load on the period value (up/down only) and on its own value
    task t_load;
        wb(1'b1, `OFS_CONTROL, ctl(0, 0, 0, 2, 0, 0, 0, 0));
        wb(1'b1, `OFS_VALUE, 16'h0070);
        cnt(16'h00FF);
        cnt(16'h0070);
        rd(`OFS_STATUS, 32'h0);
        COUNT_MODE <= `MODE_UPDOWN;
        cnt(16'h00FF);
        cnt(16'h0070);
        rd(`OFS_STATUS, 32'h2);
        wb(1'b1, `OFS_CONTROL, ctl(0, 0, 0, 3, 0, 0, 0, 0));
        wb(1'b1, `OFS_VALUE, 16'h0080);
        cnt(16'h0080);
        rd(`OFS_STATUS, 32'h2);
        COUNT_MODE <= 2'h0;
    endtask

    // Main sequence
    initial begin
        RST_B = 1'b0;
        CE = 1'b1;
        CYC_I = 1'b0;
        STB_I = 1'b0;
        WE_I = 1'b0;
        ADR_I = 8'h00;
        DAT_I = 32'h0;
        SEL_I = 4'h0;
        COUNT_VALUE = 16'h0000;
        COUNT_MODE = 2'h0;
        PERIOD_MATCH = 1'b0;
        PEND_IN = 7'h00;
        saw_clr = 1'b0;
        n_fail = 0;
        checked = 0;
        cycles = 0;
        repeat (3) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        t_regs;
        t_levels;
        t_capture;
        t_irq;
        t_vector;
        t_wave;
        t_load;
        give_verdict;
    end
endmodule
